// *** core/isr_regbank.sv ***
`timescale 1ns/1ns
`include "isr_consts.svh"

// What this block does
// [R01] while run bit set, registers 0x01..0x05 ignore writes
// [R02] host writes reserved fields only with their default values
// [R03] upper range register selects max resistance, codes 0x00-0x1f, reset 0x0e
// [R04] host must write lower range register before conversions; reset 0x14
// [R05] lower range register sets min resistance; both bound the dynamic range
// [R06] loss reading: bits 7:0 at lower address, 15:8 at next
// [R07] address zero returns a fixed read-only identity byte
// [R08] period count held as three read-only bytes, low byte first
// [R09] conversions run only while run bit is one; else standby
// [R10] address auto-increments for every further byte in a frame
// [R11] status bits 7:4 are lost, ready, wake, comparator; low nibble zero
module isr_regbank
  import isr_pkg::*;
#(
  parameter logic [7:0] IDENTITY_CODE = 8'h5a  // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        serial_sel_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_din,
  output logic             serial_dout,
  output logic             serial_dout_en,
  input  wire logic [15:0] loss_reading,
  input  wire logic [23:0] period_count,
  input  wire logic        oscillation_lost_flag,
  input  wire logic        conversion_ready_flag,
  input  wire logic        wake_event,
  input  wire logic        comparator_state,
  output logic             conversion_run_select,
  output logic [4:0]       upper_loss_range,
  output logic [7:0]       lower_loss_range,
  output logic [7:0]       oscillation_timeout_setting,
  output logic [7:0]       converter_setup,
  output logic [7:0]       count_clock_setup,
  output logic [15:0]      upper_threshold,
  output logic [15:0]      lower_threshold,
  output logic [2:0]       irq_pin_function
);

  typedef struct packed {
    logic [1:0]  sel_sync;
    logic [1:0]  clk_sync;
    logic [1:0]  din_sync;
    logic        clk_prev;
    isr_phase_t  phase;
    logic [2:0]  bit_cnt;
    logic        rd;
    logic [6:0]  addr;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic        dout;
    logic        dout_en;
    logic [7:0]  upper_range;
    logic [7:0]  lower_range;
    logic [7:0]  timeout;
    logic [7:0]  conv_setup;
    logic [7:0]  clk_setup;
    logic [7:0]  uth_lo;
    logic [7:0]  uth_hi;
    logic [7:0]  lth_lo;
    logic [7:0]  lth_hi;
    logic [7:0]  irq_setup;
    logic [7:0]  power_setup;
  } isr_state_t;

  isr_state_t st;
  isr_state_t next_st;
  logic [1:0] rst_sync;
  logic       rst_n;

  // kept apart from the state struct: it runs on the raw reset, the struct on its copy
  assign rst_n = rst_sync[1];

  // read mux over the whole map; unmapped addresses read zero
  function automatic logic [7:0] isr_read(input isr_state_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ISR_ADDR_IDENTITY:    v = IDENTITY_CODE;  // [R07]
      `ISR_ADDR_UPPER_RANGE: v = s.upper_range;
      `ISR_ADDR_LOWER_RANGE: v = s.lower_range;
      `ISR_ADDR_TIMEOUT:     v = s.timeout;
      `ISR_ADDR_CONV_SETUP:  v = s.conv_setup;
      `ISR_ADDR_CLK_SETUP:   v = s.clk_setup;
      `ISR_ADDR_UTH_LO:      v = s.uth_lo;
      `ISR_ADDR_UTH_HI:      v = s.uth_hi;
      `ISR_ADDR_LTH_LO:      v = s.lth_lo;
      `ISR_ADDR_LTH_HI:      v = s.lth_hi;
      `ISR_ADDR_IRQ_SETUP:   v = s.irq_setup;
      `ISR_ADDR_POWER_SETUP: v = s.power_setup;
      `ISR_ADDR_FLAGS:       v = {oscillation_lost_flag, conversion_ready_flag,
                                  wake_event, comparator_state, 4'h0};  // [R11]
      `ISR_ADDR_LOSS_LO:     v = loss_reading[7:0];    // [R06]
      `ISR_ADDR_LOSS_HI:     v = loss_reading[15:8];   // [R06]
      `ISR_ADDR_PCNT_LO:     v = period_count[7:0];    // [R08]
      `ISR_ADDR_PCNT_MID:    v = period_count[15:8];   // [R08]
      `ISR_ADDR_PCNT_HI:     v = period_count[23:16];  // [R08]
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // serial decode and register writes
  always_comb begin
    logic       rise;
    logic       fall;
    logic       awake;
    logic [7:0] byte_in;
    rise    = 1'b0;
    fall    = 1'b0;
    awake   = 1'b0;
    byte_in = 8'h00;
    next_st = st;
    next_st.sel_sync = {st.sel_sync[0], serial_sel_n};
    next_st.clk_sync = {st.clk_sync[0], serial_clk};
    next_st.din_sync = {st.din_sync[0], serial_din};
    next_st.clk_prev = st.clk_sync[1];
    rise  = st.clk_sync[1] & ~st.clk_prev;
    fall  = ~st.clk_sync[1] & st.clk_prev;
    awake = st.power_setup[`ISR_RUN_BIT];
    byte_in = {st.shift_in[6:0], st.din_sync[1]};
    if (st.sel_sync[1]) begin
      // frame ended; a partial byte is dropped so no write occurs
      next_st.phase   = ISR_IDLE;
      next_st.dout_en = 1'b0;
    end else begin
      if (st.phase == ISR_IDLE) begin
        next_st.phase   = ISR_CMD;
        next_st.bit_cnt = 3'd0;
        next_st.dout_en = 1'b1;
        next_st.dout    = 1'b0;
      end
      if (st.phase != ISR_IDLE && rise) begin
        next_st.shift_in = byte_in;
        next_st.bit_cnt  = st.bit_cnt + 3'd1;
        if (st.bit_cnt == `ISR_BYTE_BITS) begin
          if (st.phase == ISR_CMD) begin
            next_st.rd        = byte_in[7];
            next_st.addr      = byte_in[6:0];
            next_st.shift_out = isr_read(st, byte_in[6:0]);
            next_st.phase     = ISR_DATA;
          end else begin
            if (!st.rd) begin
              // locked config range while converting
              case (st.addr)
                `ISR_ADDR_UPPER_RANGE: if (!awake) next_st.upper_range = byte_in;  // [R01]
                `ISR_ADDR_LOWER_RANGE: if (!awake) next_st.lower_range = byte_in;  // [R01]
                `ISR_ADDR_TIMEOUT:     if (!awake) next_st.timeout = byte_in;      // [R01]
                `ISR_ADDR_CONV_SETUP:  if (!awake) next_st.conv_setup = byte_in;   // [R01]
                `ISR_ADDR_CLK_SETUP:   if (!awake) next_st.clk_setup = byte_in;    // [R01]
                `ISR_ADDR_UTH_LO:      next_st.uth_lo = byte_in;
                `ISR_ADDR_UTH_HI:      next_st.uth_hi = byte_in;
                `ISR_ADDR_LTH_LO:      next_st.lth_lo = byte_in;
                `ISR_ADDR_LTH_HI:      next_st.lth_hi = byte_in;
                `ISR_ADDR_IRQ_SETUP:   next_st.irq_setup = byte_in;
                `ISR_ADDR_POWER_SETUP: next_st.power_setup = byte_in;
                default:               next_st.addr = st.addr;  // read-only or unmapped
              endcase
            end
            next_st.addr      = st.addr + 7'd1;              // [R10]
            next_st.shift_out = isr_read(st, st.addr + 7'd1);  // [R10]
          end
        end
      end
      // output bit shifts out on falling edge, msb first
      if (st.phase == ISR_DATA && fall) begin
        next_st.dout      = st.rd & st.shift_out[7];
        next_st.shift_out = {st.shift_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.sel_sync    <= 2'b11;
      st.clk_sync    <= 2'b00;
      st.din_sync    <= 2'b00;
      st.clk_prev    <= 1'b0;
      st.phase       <= ISR_IDLE;
      st.bit_cnt     <= 3'd0;
      st.rd          <= 1'b0;
      st.addr        <= 7'h00;
      st.shift_in    <= 8'h00;
      st.shift_out   <= 8'h00;
      st.dout        <= 1'b0;
      st.dout_en     <= 1'b0;
      st.upper_range <= `ISR_RST_UPPER_RANGE;  // [R03]
      st.lower_range <= `ISR_RST_LOWER_RANGE;  // [R05]
      st.timeout     <= `ISR_RST_TIMEOUT;
      st.conv_setup  <= `ISR_RST_CONV_SETUP;
      st.clk_setup   <= `ISR_RST_CLK_SETUP;
      st.uth_lo      <= `ISR_RST_UTH;
      st.uth_hi      <= `ISR_RST_UTH;
      st.lth_lo      <= `ISR_RST_LTH;
      st.lth_hi      <= `ISR_RST_LTH;
      st.irq_setup   <= `ISR_RST_IRQ_SETUP;
      st.power_setup <= `ISR_RST_POWER_SETUP;  // standby after reset
    end else begin
      st.sel_sync    <= next_st.sel_sync;
      st.clk_sync    <= next_st.clk_sync;
      st.din_sync    <= next_st.din_sync;
      st.clk_prev    <= next_st.clk_prev;
      st.phase       <= next_st.phase;
      st.bit_cnt     <= next_st.bit_cnt;
      st.rd          <= next_st.rd;
      st.addr        <= next_st.addr;
      st.shift_in    <= next_st.shift_in;
      st.shift_out   <= next_st.shift_out;
      st.dout        <= next_st.dout;
      st.dout_en     <= next_st.dout_en;
      st.upper_range <= next_st.upper_range;
      st.lower_range <= next_st.lower_range;
      st.timeout     <= next_st.timeout;
      st.conv_setup  <= next_st.conv_setup;
      st.clk_setup   <= next_st.clk_setup;
      st.uth_lo      <= next_st.uth_lo;
      st.uth_hi      <= next_st.uth_hi;
      st.lth_lo      <= next_st.lth_lo;
      st.lth_hi      <= next_st.lth_hi;
      st.irq_setup   <= next_st.irq_setup;
      st.power_setup <= next_st.power_setup;
    end
  end

  // outputs straight from state flops
  assign serial_dout                 = st.dout;
  assign serial_dout_en              = st.dout_en;
  assign conversion_run_select       = st.power_setup[`ISR_RUN_BIT];              // [R09]
  assign upper_loss_range            = st.upper_range[`ISR_RANGE_CODE_MSB:0];     // [R03]
  assign lower_loss_range            = st.lower_range;                            // [R05]
  assign oscillation_timeout_setting = st.timeout;
  assign converter_setup             = st.conv_setup;
  assign count_clock_setup           = st.clk_setup;
  assign upper_threshold             = {st.uth_hi, st.uth_lo};
  assign lower_threshold             = {st.lth_hi, st.lth_lo};
  assign irq_pin_function            = st.irq_setup[2:0];

endmodule

// *** core/isr_consts.svh ***
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH

// register offsets (7-bit serial address)
`define ISR_ADDR_IDENTITY     7'h00
`define ISR_ADDR_UPPER_RANGE  7'h01
`define ISR_ADDR_LOWER_RANGE  7'h02
`define ISR_ADDR_TIMEOUT      7'h03
`define ISR_ADDR_CONV_SETUP   7'h04
`define ISR_ADDR_CLK_SETUP    7'h05
`define ISR_ADDR_UTH_LO       7'h06
`define ISR_ADDR_UTH_HI       7'h07
`define ISR_ADDR_LTH_LO       7'h08
`define ISR_ADDR_LTH_HI       7'h09
`define ISR_ADDR_IRQ_SETUP    7'h0a
`define ISR_ADDR_POWER_SETUP  7'h0b
`define ISR_ADDR_FLAGS        7'h20
`define ISR_ADDR_LOSS_LO      7'h21
`define ISR_ADDR_LOSS_HI      7'h22
`define ISR_ADDR_PCNT_LO      7'h23
`define ISR_ADDR_PCNT_MID     7'h24
`define ISR_ADDR_PCNT_HI      7'h25

// reset values
`define ISR_RST_UPPER_RANGE   8'h0e
`define ISR_RST_LOWER_RANGE   8'h14
`define ISR_RST_TIMEOUT       8'h45
`define ISR_RST_CONV_SETUP    8'h1b
`define ISR_RST_CLK_SETUP     8'h01
`define ISR_RST_UTH           8'hff
`define ISR_RST_LTH           8'h00
`define ISR_RST_IRQ_SETUP     8'h00
`define ISR_RST_POWER_SETUP   8'h00

// field positions
`define ISR_RUN_BIT           0
`define ISR_RANGE_CODE_MSB    4
`define ISR_FLAG_LOST_BIT     7
`define ISR_FLAG_READY_BIT    6
`define ISR_FLAG_WAKE_BIT     5
`define ISR_FLAG_COMP_BIT     4

// serial framing
`define ISR_BYTE_BITS         3'd7

`endif

// *** core/isr_pkg.sv ***
package isr_pkg;
  // serial frame phase
  typedef enum logic [1:0] {
    ISR_IDLE,
    ISR_CMD,
    ISR_DATA
  } isr_phase_t;
endpackage

// *** tb/isr_host.sv ***
`timescale 1ns/1ns
// host-side serial master; serial clock stands low between frames
module isr_host (
  input  wire logic core_clk,
  input  wire logic serial_dout,
  output logic      serial_sel_n,
  output logic      serial_clk,
  output logic      serial_din
);
  initial begin
    serial_sel_n = 1'b1;
    serial_clk   = 1'b0;
    serial_din   = 1'b0;
  end
  // command then data bits, byte k at wd[8k+7:8k]; 6-cycle phases clear the 4-cycle minimum
  task automatic frame(input logic [7:0] cmd, input int nbits, input logic [47:0] wd,
                       output logic [47:0] rd);
    int i;
    int j;
    rd = '0;
    serial_sel_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (i = 0; i < nbits; i++) begin
      j = (i < 8) ? 0 : (i - 8) / 8 * 8 + 7 - (i - 8) % 8;
      serial_din <= (i < 8) ? cmd[7-i] : wd[j];
      repeat (6) @(posedge core_clk);
      if (i >= 8) rd[j] = serial_dout; // settled long after the falling edge
      serial_clk <= 1'b1;
      repeat (6) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    serial_sel_n <= 1'b1;
    serial_din   <= ~serial_din; // released line must not keep its last value
    repeat (10) @(posedge core_clk);
  endtask
endmodule

// *** tb/isr_regbank_properties.sv ***
`timescale 1ns/1ns
module isr_regbank_properties (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        serial_sel_n,
  input wire logic        serial_clk,
  input wire logic        serial_dout,
  input wire logic        serial_dout_en,
  input wire logic        conversion_run_select,
  input wire logic [4:0]  upper_loss_range,
  input wire logic [7:0]  lower_loss_range,
  input wire logic [7:0]  oscillation_timeout_setting,
  input wire logic [7:0]  converter_setup,
  input wire logic [7:0]  count_clock_setup,
  input wire logic [15:0] upper_threshold,
  input wire logic [15:0] lower_threshold,
  input wire logic [2:0]  irq_pin_function
);
  logic [72:0] cfg;
  logic [36:0] locked;
  // every output port the host can write, and the part the run bit freezes
  assign locked = {upper_loss_range, lower_loss_range, oscillation_timeout_setting,
                   converter_setup, count_clock_setup};
  assign cfg = {locked, conversion_run_select, upper_threshold, lower_threshold,
                irq_pin_function};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_idle; serial_sel_n [*8]; endsequence
  sequence s_sel; !serial_sel_n [*5]; endsequence
  a_dout_en_off: assert property (s_idle |-> !serial_dout_en)
    else $error("output enable high while deselected");
  a_dout_en_on: assert property (s_sel |-> serial_dout_en)
    else $error("output enable low while selected");
  a_dout_moves_low: assert property ($changed(serial_dout) |-> !serial_clk && !$past(serial_clk))
    else $error("serial output changed outside the low phase");
  a_run_lock_upper: assert property ($past(conversion_run_select) && conversion_run_select |-> $stable(upper_loss_range))
    else $error("upper range changed while running");
  a_run_lock_setup: assert property ($past(conversion_run_select) && conversion_run_select |-> $stable(locked[31:0]))
    else $error("setup changed while running");
  a_cfg_idle_quiet: assert property (s_idle |-> $stable(cfg))
    else $error("configuration changed with no frame");
  a_cfg_in_frame: assert property ($changed(cfg) |-> serial_dout_en)
    else $error("configuration changed outside a frame");
  a_reset_dflt: assert property ($rose(resetn) |-> cfg == {5'h0e, 8'h14, 8'h45, 8'h1b, 8'h01, 1'b0, 16'hffff, 16'h0000, 3'h0})
    else $error("register defaults wrong after reset");
endmodule
bind isr_regbank isr_regbank_properties chk_u (.*);

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        core_clk, resetn, serial_sel_n, serial_clk, serial_din, serial_dout;
  logic        serial_dout_en, conversion_run_select;
  logic        oscillation_lost_flag, conversion_ready_flag, wake_event, comparator_state;
  logic [15:0] loss_reading, upper_threshold, lower_threshold;
  logic [23:0] period_count;
  logic [4:0]  upper_loss_range;
  logic [7:0]  lower_loss_range, oscillation_timeout_setting, converter_setup, count_clock_setup;
  logic [2:0]  irq_pin_function;
  logic [47:0] rd;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // address, write data; reserved fields kept at their defaults
  logic [15:0] rows [10] = '{16'h011f, 16'h023b, 16'h03b3, 16'h040a, 16'h0502,
                             16'h0634, 16'h0712, 16'h08cd, 16'h09ab, 16'h0a04};
  // identity value is arbitrary
  isr_regbank #(.IDENTITY_CODE(8'h3c)) dut_u (.*);
  isr_host host_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.frame({1'b0, a}, 16, {40'h0, d}, rd);
  endtask
  task automatic rdn(input logic [6:0] a, input int n);
    host_u.frame({1'b1, a}, 8 + 8 * n, 48'h0, rd);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    #300us;
    error_cnt++;
    complete_run;
  end
  initial begin
    resetn = 1'b0;
    loss_reading = 16'hbeef;
    period_count = 24'h123456;
    {oscillation_lost_flag, conversion_ready_flag, wake_event, comparator_state} = 4'b1010;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("dflt_ports", {upper_threshold, lower_threshold, irq_pin_function,
        conversion_run_select}, {16'hffff, 16'h0, 3'h0, 1'b0});
    rdn(7'h00, 6);
    chk("dflt_regs", rd, {8'h01, 8'h1b, 8'h45, 8'h14, 8'h0e, 8'h3c});
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      wr(rows[k][14:8], rows[k][7:0]);
      rdn(rows[k][14:8], 1);
      chk("readback", rd, {40'h0, rows[k][7:0]});
    end
    chk("range_ports", {upper_loss_range, lower_loss_range, oscillation_timeout_setting,
        converter_setup, count_clock_setup}, {5'h1f, 32'h3bb30a02});
    chk("thr_ports", {upper_threshold, lower_threshold, irq_pin_function},
        {16'h1234, 16'habcd, 3'h4});
    $display("test table done");
    rdn(7'h20, 6);
    chk("readings", rd[47:4], {24'h123456, 16'hbeef, 4'ha});
    {oscillation_lost_flag, conversion_ready_flag, wake_event, comparator_state} <= 4'b0101;
    rdn(7'h20, 1);
    chk("flags", rd[7:4], 4'h5);
    $display("test readings done");
    wr(7'h0b, 8'h01);
    chk("run_on", conversion_run_select, 1'b1);
    wr(7'h01, 8'h05);
    wr(7'h0a, 8'h02);
    // burst into 0x02..0x05 while running; reserved fields kept at defaults
    host_u.frame(8'h02, 40, 48'h0000_0013_6655, rd);
    chk("locked", {upper_loss_range, lower_loss_range, oscillation_timeout_setting,
        converter_setup, count_clock_setup, irq_pin_function},
        {5'h1f, 32'h3bb30a02, 3'h2});
    wr(7'h0b, 8'h00);
    wr(7'h01, 8'h05);
    chk("unlocked", {upper_loss_range, conversion_run_select}, {5'h05, 1'b0});
    $display("test run lock done");
    wr(7'h00, 8'hff);
    host_u.frame(8'h02, 12, 48'h0, rd);
    chk("partial", lower_loss_range, 8'h3b);
    rdn(7'h00, 1);
    chk("ro_ident", rd, 48'h3c);
    rdn(7'h40, 1);
    chk("unmapped", rd, 48'h0);
    $display("test refusals done");
    // burst write lands byte by byte at rising addresses
    host_u.frame(8'h06, 40, 48'h0000_5566_7788, rd);
    chk("burst_wr", {upper_threshold, lower_threshold}, {16'h7788, 16'h5566});
    $display("test burst write done");
    // reset in standby must bring every written register back to its default
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("rst_again", {upper_loss_range, lower_loss_range, upper_threshold,
        irq_pin_function}, {5'h0e, 8'h14, 16'hffff, 3'h0});
    rdn(7'h02, 1);
    chk("rst_lower", rd, 48'h14);
    $display("test second reset done");
    complete_run;
  end
endmodule
